// File: core/sse_top.sv
`timescale 1ns/100ps
module sse_top
  import sse_pkg::*;
#(
  parameter logic [15:0] SENSOR_HANDLE  = 16'h0001,
  parameter logic [3:0]  NUM_SETS       = 4'h8,
  parameter logic [7:0]  EVENT_CAPABLE  = 8'h0f,
  parameter logic        INIT_SUPPORTED = 1'b1
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_RD    = 5'b00100,
    ST_WR    = 5'b01000,
    ST_DONE  = 5'b10000
  } sse_fsm_t;

  typedef struct packed {
    sse_fsm_t               st;
    logic [1:0]             cmd;
    logic [2:0]             idx;
    logic [2:0]             last;
    logic [15:0]            handle;
    logic [7:0]             count;
    logic [7:0][15:0]       entry;
    logic [7:0][MEM_W-1:0]  snap;
    logic [7:0]             result;
    logic [3:0]             rep_count;
    logic [1:0]             irq_status;
    logic [1:0]             irq_mask;
    logic                   ack;
    logic [31:0]            rdata;
  } sse_reg_t;

  sse_reg_t         r;
  sse_reg_t         next_r;
  logic [MEM_W-1:0] mem_rdata;
  logic [MEM_W-1:0] mem_wdata;
  logic             mem_wr;
  logic             mem_rd;
  logic             req;
  logic             acc;
  logic             handle_bad;
  logic             count_bad;
  logic [7:0]       op_bad;
  logic [7:0]       ev_bad;
  logic [7:0]       ev_unsup;
  logic [7:0]       cnt_m1;
  logic [31:0]      rd_mux;

  // -------------------------------------------------------------------------
  // Byte lane merge for register writes.
  // -------------------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // -------------------------------------------------------------------------
  // Request checks.
  // -------------------------------------------------------------------------
  // reserved or unknown handle rejection
  assign handle_bad = (r.handle == HANDLE_RSVD_LO) || (r.handle == HANDLE_RSVD_HI) ||
                      (r.handle != SENSOR_HANDLE);
  assign count_bad  = (r.count < SET_COUNT_MIN) || (r.count > SET_COUNT_MAX) ||
                      (r.count > {4'h0, NUM_SETS});
  assign cnt_m1     = r.count - 8'h01;

  // Each counted entry is checked for legal codes and for event support.
  for (genvar i = 0; i < 8; i++)
  begin : g_chk
    logic active;
    assign active      = r.count > 8'(i);
    assign op_bad[i]   = active && (r.entry[i][ENT_OP_LSB +: 8] > OP_UNAVAILABLE);
    assign ev_bad[i]   = active && (r.entry[i][ENT_EV_LSB +: 8] > EV_STATE_ONLY);
    assign ev_unsup[i] = active && !EVENT_CAPABLE[i] &&
                         (r.entry[i][ENT_EV_LSB +: 8] >= EV_ON);
  end

  // -------------------------------------------------------------------------
  // Avalon-MM handshake: one wait cycle, then the access completes.
  // -------------------------------------------------------------------------
  assign req             = avs_read || avs_write;
  assign acc             = req && r.ack;
  assign avs_waitrequest = req && !r.ack;
  assign avs_readdata    = r.rdata;
  assign irq             = |(r.irq_status & r.irq_mask);

  // Read data selection by address; unmapped words read as zero.
  always_comb
  begin
    rd_mux = '0;
    if (avs_address[7:5] == WIN_ENTRY)
    begin
      rd_mux[15:0] = r.entry[avs_address[4:2]];
    end
    else if (avs_address[7:5] == WIN_SNAP)
    begin
      rd_mux[MEM_W-1:0] = r.snap[avs_address[4:2]];
    end
    else
    begin
      unique case (avs_address)
        REG_CTRL:       rd_mux[1:0]  = r.cmd;
        REG_HANDLE:     rd_mux[15:0] = r.handle;
        REG_COUNT:      rd_mux[7:0]  = r.count;
        REG_RESULT:
        begin
          rd_mux[RES_CODE_LSB +: 8]  = r.result;
          rd_mux[RES_BUSY_BIT]       = r.st != ST_IDLE;
          rd_mux[RES_COUNT_LSB +: 4] = r.rep_count;
        end
        REG_IRQ_STATUS: rd_mux[1:0]  = r.irq_status;
        REG_IRQ_MASK:   rd_mux[1:0]  = r.irq_mask;
        default:        rd_mux       = '0;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Sensor store access.
  // -------------------------------------------------------------------------
  assign mem_rd = r.st == ST_RD;
  assign mem_wr = (r.st == ST_WR) && (r.cmd != CMD_READ_STATES);

  // Merge the entry with the stored word, or load defaults on init.
  always_comb
  begin
    if (r.cmd == CMD_INIT_SENSOR)
    begin
      mem_wdata = MEM_RESET_WD;
    end
    else if (r.entry[r.idx][ENT_EV_LSB +: 8] == EV_KEEP)
    begin
      mem_wdata = {mem_rdata[MEM_W-1:MEM_OP_W], r.entry[r.idx][ENT_OP_LSB +: MEM_OP_W]};
    end
    else
    begin
      mem_wdata = {r.entry[r.idx][ENT_EV_LSB +: MEM_EV_W],
                   r.entry[r.idx][ENT_OP_LSB +: MEM_OP_W]};
    end
  end

  sse_state_mem u_mem (
    .clk     (clk),
    .nrst    (nrst),
    .wr_en   (mem_wr),
    .wr_addr (r.idx),
    .wr_data (mem_wdata),
    .rd_en   (mem_rd),
    .rd_addr (r.idx),
    .rd_data (mem_rdata)
  );

  // -------------------------------------------------------------------------
  // Next state: bus registers, command sequencer and interrupt flags.
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_r     = r;
    next_r.ack = req && !r.ack;
    if (req && !r.ack && avs_read)
    begin
      next_r.rdata = rd_mux;
    end
    // Status read clears only the bits that were returned.
    if (acc && avs_read && (avs_address == REG_IRQ_STATUS))
    begin
      next_r.irq_status = r.irq_status & ~r.rdata[1:0];
    end
    if (acc && avs_write)
    begin
      if (avs_address == REG_IRQ_MASK)
      begin
        next_r.irq_mask = 2'(be_merge({30'h0, r.irq_mask}, avs_writedata, avs_byteenable));
      end
      else if (r.st == ST_IDLE)
      begin
        if (avs_address == REG_CTRL && avs_byteenable[0])
        begin
          next_r.cmd = avs_writedata[1:0];
          next_r.st  = ST_CHECK;
        end
        else if (avs_address == REG_HANDLE)
        begin
          next_r.handle = 16'(be_merge({16'h0, r.handle}, avs_writedata, avs_byteenable));
        end
        else if (avs_address == REG_COUNT)
        begin
          next_r.count = 8'(be_merge({24'h0, r.count}, avs_writedata, avs_byteenable));
        end
        else if (avs_address[7:5] == WIN_ENTRY)
        begin
          next_r.entry[avs_address[4:2]] =
            16'(be_merge({16'h0, r.entry[avs_address[4:2]]}, avs_writedata, avs_byteenable));
        end
      end
    end
    unique case (r.st)
      ST_IDLE:
      begin
      end
      ST_CHECK:
      begin
        next_r.idx       = 3'h0;
        next_r.last      = 3'(NUM_SETS - 4'h1);
        next_r.rep_count = 4'h0;
        next_r.result    = SUCCESS_CODE;
        next_r.st        = ST_DONE;
        unique case (r.cmd)
          CMD_SET_ENABLES:
          begin
            if (handle_bad)
              next_r.result = BAD_HANDLE_CODE;
            else if (count_bad || (|op_bad) || (|ev_bad))
              next_r.result = INVALID_DATA_CODE;
            else if (|ev_unsup)
              next_r.result = NO_EVENT_SUPPORT_CODE;
            else
            begin
              next_r.last = cnt_m1[2:0];
              next_r.st   = ST_RD;
            end
          end
          CMD_READ_STATES:
          begin
            if (handle_bad)
              next_r.result = BAD_HANDLE_CODE;
            else
            begin
              next_r.rep_count = NUM_SETS;
              next_r.st        = ST_RD;
            end
          end
          CMD_INIT_SENSOR:
          begin
            if (!INIT_SUPPORTED)
              next_r.result = UNSUPPORTED_CMD_CODE;
            else if (handle_bad)
              next_r.result = BAD_HANDLE_CODE;
            else
              next_r.st = ST_RD;
          end
          default: next_r.result = UNSUPPORTED_CMD_CODE;
        endcase
      end
      ST_RD:
      begin
        next_r.st = ST_WR;
      end
      ST_WR:
      begin
        if (r.cmd == CMD_READ_STATES)
        begin
          next_r.snap[r.idx] = mem_rdata;
        end
        if (r.idx == r.last)
        begin
          next_r.st = ST_DONE;
        end
        else
        begin
          next_r.idx = r.idx + 3'h1;
          next_r.st  = ST_RD;
        end
      end
      ST_DONE:
      begin
        // Completion flags are set after any clear so a new event wins.
        next_r.irq_status[IRQ_DONE_BIT] = 1'b1;
        if (r.result != SUCCESS_CODE)
        begin
          next_r.irq_status[IRQ_ERR_BIT] = 1'b1;
        end
        next_r.st = ST_IDLE;
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r    <= '0;
      r.st <= ST_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions.
  // -------------------------------------------------------------------------
  sequence s_check_set;
    r.st == ST_CHECK && r.cmd == CMD_SET_ENABLES;
  endsequence

  sequence s_idle_again;
    ##[1:20] (r.st == ST_IDLE);
  endsequence

  property p_bad_handle;
    @(posedge clk) disable iff (!nrst)
      s_check_set and handle_bad |=> r.result == BAD_HANDLE_CODE && r.st == ST_DONE;
  endproperty
  a_bad_handle: assert property (p_bad_handle) else $error("Bad handle not reported.");

  property p_count_range;
    @(posedge clk) disable iff (!nrst)
      s_check_set and (!handle_bad && count_bad) |=> r.result == INVALID_DATA_CODE;
  endproperty
  a_count_range: assert property (p_count_range) else $error("Bad count accepted.");

  property p_no_event;
    @(posedge clk) disable iff (!nrst)
      s_check_set and (!handle_bad && !count_bad && !(|op_bad) && !(|ev_bad) && (|ev_unsup))
      |=> r.result == NO_EVENT_SUPPORT_CODE ##1 r.irq_status[IRQ_ERR_BIT];
  endproperty
  a_no_event: assert property (p_no_event) else $error("Event support error missed.");

  property p_keep;
    @(posedge clk) disable iff (!nrst)
      mem_wr && r.cmd == CMD_SET_ENABLES && r.entry[r.idx][ENT_EV_LSB +: 8] == EV_KEEP
      |-> mem_wdata[MEM_W-1:MEM_OP_W] == mem_rdata[MEM_W-1:MEM_OP_W];
  endproperty
  a_keep: assert property (p_keep) else $error("Keep setting altered events.");

  property p_op_apply;
    @(posedge clk) disable iff (!nrst)
      mem_wr && r.cmd == CMD_SET_ENABLES
      |-> mem_wdata[MEM_OP_W-1:0] == r.entry[r.idx][MEM_OP_W-1:0];
  endproperty
  a_op_apply: assert property (p_op_apply) else $error("Operational state not applied.");

  property p_ev_apply;
    @(posedge clk) disable iff (!nrst)
      mem_wr && r.cmd == CMD_SET_ENABLES && r.entry[r.idx][ENT_EV_LSB +: 8] != EV_KEEP
      |-> mem_wdata[MEM_W-1:MEM_OP_W] == r.entry[r.idx][ENT_EV_LSB +: MEM_EV_W];
  endproperty
  a_ev_apply: assert property (p_ev_apply) else $error("Event control not applied.");

  property p_set_range;
    @(posedge clk) disable iff (!nrst)
      mem_wr |-> {1'b0, r.idx} < NUM_SETS && (r.cmd != CMD_SET_ENABLES || r.idx <= cnt_m1[2:0]);
  endproperty
  a_set_range: assert property (p_set_range) else $error("Write beyond addressed sets.");

  property p_walk_done;
    @(posedge clk) disable iff (!nrst)
      (r.st == ST_CHECK) |-> s_idle_again;
  endproperty
  a_walk_done: assert property (p_walk_done) else $error("Command did not finish.");

  property p_done_flag;
    @(posedge clk) disable iff (!nrst)
      (r.st == ST_DONE) |=> r.irq_status[IRQ_DONE_BIT] && r.st == ST_IDLE;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("Done flag not set.");

endmodule // sse_top

// File: core/sse_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants of the state sensor enable command block.
// ---------------------------------------------------------------------------
package sse_pkg;

  // -------------------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave.
  // -------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL       = 8'h00; // Write starts a command.
  localparam logic [7:0] REG_HANDLE     = 8'h04; // Sensor handle of the request.
  localparam logic [7:0] REG_COUNT      = 8'h08; // Sensor set count of the request.
  localparam logic [7:0] REG_RESULT     = 8'h0c; // Result code, busy, reported count.
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10; // Sticky events, cleared by read.
  localparam logic [7:0] REG_IRQ_MASK   = 8'h14; // Interrupt enables.
  localparam logic [2:0] WIN_ENTRY      = 3'h1;  // Entries at 0x20 + 4 * index.
  localparam logic [2:0] WIN_SNAP       = 3'h2;  // Snapshots at 0x40 + 4 * index.

  // -------------------------------------------------------------------------
  // Field positions.
  // -------------------------------------------------------------------------
  localparam int RES_CODE_LSB  = 0;
  localparam int RES_BUSY_BIT  = 8;
  localparam int RES_COUNT_LSB = 16;
  localparam int ENT_OP_LSB    = 0;
  localparam int ENT_EV_LSB    = 8;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ERR_BIT   = 1;

  // -------------------------------------------------------------------------
  // Command codes written to the control register.
  // -------------------------------------------------------------------------
  localparam logic [1:0] CMD_SET_ENABLES = 2'h0; // set_sensor_enables_cmd
  localparam logic [1:0] CMD_READ_STATES = 2'h1; // read_sensor_states_cmd
  localparam logic [1:0] CMD_INIT_SENSOR = 2'h2; // init_state_sensor_cmd

  // -------------------------------------------------------------------------
  // Request field values.
  // -------------------------------------------------------------------------
  localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
  localparam logic [15:0] HANDLE_RSVD_HI = 16'hffff;
  localparam logic [7:0]  SET_COUNT_MIN  = 8'h01;
  localparam logic [7:0]  SET_COUNT_MAX  = 8'h08;
  localparam logic [7:0]  OP_ENABLED     = 8'h00;
  localparam logic [7:0]  OP_DISABLED    = 8'h01;
  localparam logic [7:0]  OP_UNAVAILABLE = 8'h02;
  localparam logic [7:0]  EV_KEEP        = 8'h00; // keep_setting
  localparam logic [7:0]  EV_OFF         = 8'h01; // events_off
  localparam logic [7:0]  EV_ON          = 8'h02; // events_on
  localparam logic [7:0]  EV_OP_ONLY     = 8'h03; // op_events_only
  localparam logic [7:0]  EV_STATE_ONLY  = 8'h04; // state_events_only

  // -------------------------------------------------------------------------
  // Result codes.
  // -------------------------------------------------------------------------
  localparam logic [7:0] SUCCESS_CODE          = 8'h00;
  localparam logic [7:0] INVALID_DATA_CODE     = 8'h02;
  localparam logic [7:0] UNSUPPORTED_CMD_CODE  = 8'h05;
  localparam logic [7:0] BAD_HANDLE_CODE       = 8'h80;
  localparam logic [7:0] NO_EVENT_SUPPORT_CODE = 8'h82;

  // -------------------------------------------------------------------------
  // Stored sensor word: event setting above operational state.
  // -------------------------------------------------------------------------
  localparam int         MEM_OP_W     = 2;
  localparam int         MEM_EV_W     = 3;
  localparam int         MEM_W        = MEM_OP_W + MEM_EV_W;
  localparam int         MEM_DEPTH    = 8;
  localparam logic [4:0] MEM_RESET_WD = {EV_OFF[2:0], OP_ENABLED[1:0]};

endpackage

// File: core/sse_state_mem.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Per-set sensor state store with a registered read port.
// ---------------------------------------------------------------------------
module sse_state_mem
  import sse_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wr_en,
  input  wire logic [2:0]       wr_addr,
  input  wire logic [MEM_W-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [2:0]       rd_addr,
  output logic      [MEM_W-1:0] rd_data
);

  typedef struct packed {
    logic [MEM_DEPTH-1:0][MEM_W-1:0] word;
    logic [MEM_W-1:0]                rdata;
  } sse_mem_t;

  sse_mem_t r;
  sse_mem_t next_r;

  // Write one word and capture the addressed word on a read.
  always_comb
  begin
    next_r = r;
    if (wr_en)
    begin
      next_r.word[wr_addr] = wr_data;
    end
    if (rd_en)
    begin
      next_r.rdata = r.word[rd_addr];
    end
  end

  // Every set starts enabled with events off.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '{word: {MEM_DEPTH{MEM_RESET_WD}}, rdata: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rd_data = r.rdata;

endmodule // sse_state_mem

// File: testbench/sse_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Requester model that drives the register bus of the command block.
// ---------------------------------------------------------------------------
module sse_host_model
(
  input  wire logic        clk,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // Bus starts idle; all lanes are always enabled.
  initial
  begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hf;
  end

  // Holds the request until waitrequest is seen low; only the watchdog ends a hang.
  task automatic wait_ack();
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
  endtask

  // Write cycle; released lines show inverted values so stale data cannot match.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_ack();
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask

  // Read cycle; data is taken at the edge that sees waitrequest low.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read    <= 1'b0;
    avs_address <= ~a;
  endtask
endmodule // sse_host_model

// File: testbench/sse_top_tb.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// Self-checking bench for the state sensor enable command block.
// ---------------------------------------------------------------------------
module sse_top_tb
  import sse_pkg::*;
;
  localparam logic [15:0] HANDLE = 16'h0001; // Arbitrary valid handle.
  logic        clk;
  logic        nrst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [31:0] rdata;
  logic [1:0]  exp_op [8];
  logic [2:0]  exp_ev [8];
  logic [1:0]  p_op [8];
  logic [2:0]  p_ev [8];
  logic [7:0]  evs [8] = '{8'h00, 8'h04, 8'h02, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
  logic [15:0] hs [6] = '{16'h0000, 16'hffff, 16'h0002, 16'h0000, HANDLE, HANDLE};
  logic [7:0]  ns [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h09};
  logic [7:0]  cs [6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h02, 8'h02};
  int          fails;
  int          total_checks;

  sse_top #(.SENSOR_HANDLE(HANDLE)) sse_top_inst (
    .clk            (clk),
    .nrst           (nrst),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq            (irq)
  );

  sse_host_model sse_host_model_inst (
    .clk            (clk),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // Free-running 100 MHz clock.
  initial
    clk = 1'b0;
  always
    #5 clk = ~clk;

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Loads a request, starts it and polls until the block is idle again.
  task automatic run(input logic [1:0] c, input logic [15:0] h, input logic [7:0] n);
    sse_host_model_inst.wr(REG_HANDLE, {16'h0000, h});
    sse_host_model_inst.wr(REG_COUNT, {24'h000000, n});
    sse_host_model_inst.wr(REG_CTRL, {30'h0, c});
    rdata = 32'hffffffff;
    while (rdata[RES_BUSY_BIT] !== 1'b0)
      sse_host_model_inst.rd(REG_RESULT, rdata);
  endtask

  // Writes one entry and notes what the set should hold if it is applied.
  task automatic ent(input int i, input logic [7:0] op, input logic [7:0] ev);
    sse_host_model_inst.wr(8'h20 + 8'(4 * i), {16'h0000, ev, op});
    p_op[i] = op[1:0];
    p_ev[i] = (ev == EV_KEEP) ? exp_ev[i] : ev[2:0];
  endtask

  // Reads every set back through the read-states command.
  task automatic check_snaps();
    run(CMD_READ_STATES, HANDLE, 8'h08);
    chk(rdata, {12'h000, 4'h8, 16'h0000});
    for (int i = 0; i < 8; i++)
    begin
      sse_host_model_inst.rd(8'h40 + 8'(4 * i), rdata);
      chk(rdata, {27'h0, exp_ev[i], exp_op[i]});
    end
  endtask

  // Expects the store to hold its reset contents.
  task automatic defaults();
    for (int i = 0; i < 8; i++)
    begin
      exp_op[i] = OP_ENABLED[1:0];
      exp_ev[i] = EV_OFF[2:0];
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("Error at %0t: timeout", $time);
    wrap_up();
  end

  // Main test sequence.
  initial
  begin
    fails = 0;
    total_checks = 0;
    nrst = 1'b0;
    defaults();
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    check_snaps();
    // All eight sets, every state and event choice; incapable sets get keep or off.
    for (int i = 0; i < 8; i++)
      ent(i, 8'(i % 3), evs[i]);
    run(CMD_SET_ENABLES, HANDLE, SET_COUNT_MAX);
    chk(rdata, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      exp_op[i] = p_op[i];
      exp_ev[i] = p_ev[i];
    end
    check_snaps();
    // Short count: only the first two entries apply; keep leaves events alone.
    ent(0, OP_DISABLED, EV_OFF);
    ent(1, OP_ENABLED, EV_KEEP);
    run(CMD_SET_ENABLES, HANDLE, 8'h02);
    chk(rdata, 32'h0);
    sse_host_model_inst.rd(REG_COUNT, rdata);
    chk(rdata, 32'h2);
    sse_host_model_inst.rd(REG_HANDLE, rdata);
    chk(rdata, {16'h0000, HANDLE});
    for (int i = 0; i < 2; i++)
    begin
      exp_op[i] = p_op[i];
      exp_ev[i] = p_ev[i];
    end
    check_snaps();
    // Reserved or unknown handles and counts out of range.
    for (int k = 0; k < 6; k++)
    begin
      run(CMD_SET_ENABLES, hs[k], ns[k]);
      chk(rdata, {24'h0, cs[k]});
    end
    // A reserved handle is refused by the read-states command as well.
    run(CMD_READ_STATES, 16'hffff, 8'h08);
    chk(rdata, {24'h0, BAD_HANDLE_CODE});
    ent(4, OP_DISABLED, EV_ON);
    run(CMD_SET_ENABLES, HANDLE, 8'h05);
    chk(rdata, {24'h0, NO_EVENT_SUPPORT_CODE});
    ent(2, 8'h03, EV_KEEP);
    run(CMD_SET_ENABLES, HANDLE, 8'h05);
    chk(rdata, {24'h0, INVALID_DATA_CODE});
    check_snaps();
    // Init command, its handle check and an unsupported code.
    run(CMD_INIT_SENSOR, 16'hffff, 8'h08);
    chk(rdata, {24'h0, BAD_HANDLE_CODE});
    run(CMD_INIT_SENSOR, HANDLE, 8'h08);
    chk(rdata, 32'h0);
    defaults();
    check_snaps();
    run(2'h3, HANDLE, 8'h01);
    chk(rdata, {24'h0, UNSUPPORTED_CMD_CODE});
    // Sticky status, mask and clear by read.
    sse_host_model_inst.rd(REG_IRQ_STATUS, rdata);
    chk(rdata, 32'h3);
    chk({31'h0, irq}, 32'h0);
    sse_host_model_inst.wr(REG_IRQ_MASK, 32'h3);
    run(CMD_SET_ENABLES, 16'h0000, 8'h01);
    chk({31'h0, irq}, 32'h1);
    sse_host_model_inst.rd(REG_IRQ_STATUS, rdata);
    chk(rdata, 32'h3);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    sse_host_model_inst.wr(REG_IRQ_MASK, 32'h0);
    run(CMD_SET_ENABLES, HANDLE, 8'h01);
    chk({31'h0, irq}, 32'h0);
    sse_host_model_inst.rd(REG_IRQ_STATUS, rdata);
    chk(rdata, 32'h1);
    sse_host_model_inst.rd(8'h80, rdata);
    chk(rdata, 32'h0);
    wrap_up();
  end
endmodule // sse_top_tb
